// *** sad_decoder.sv ***
/*
 * sad_decoder: system address decoder between the processor bus and the
 * memories and register files. Assumes the processor holds its request
 * until it is taken and that every target answers reads combinationally
 * in the cycle its select is high.
 */
`timescale 1ns/1ps
// Functional notes
// - only the low 64K and the upper flash window are decoded.
// - 0000-BFFF selects program flash.
// - C000-CBFF selects static RAM.
// - E000-E5FF selects boot ROM.
// - E800-EFFF and F000-F07F select the two data flash arrays.
// - F080-F3FF is reserved and selects nothing.
// - F400-F7FF selects the CAN space.
// - CAN message buffers are 16-byte blocks from F400 to F4F0.
// - CAN word registers sit at even addresses F500 to F51E.
// - F800-FAFF selects bus interface unit peripherals.
// - FB00-FBFF selects I/O expansion; ports B and C decode inside.
// - FC00-FFFF selects peripherals with a sub-range id.
// - 1C000-1FFFF selects the upper program flash window.
// - byte registers take byte transactions only.
// - word registers take word transactions only.
// - registers sit at even addresses; byte registers use low data lines.
// - reserved bits read back as whatever the target drives.
module sad_decoder
	import sad_pkg::*;
(
	// clock and reset
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	// processor side
	input wire logic [sad_pkg::ADDR_W-1:0] BUS_ADDR_I,
	input wire logic BUS_RD_I,
	input wire logic BUS_WR_I,
	input wire logic BUS_WORD_I,
	input wire logic [sad_pkg::DATA_W-1:0] BUS_WDATA_I,
	output logic BUS_BUSY_O,
	output logic BUS_READY_O,
	output logic BUS_ERR_O,
	output logic [sad_pkg::DATA_W-1:0] BUS_RDATA_O,
	// target side
	input wire logic [sad_pkg::TGT_N-1:0][sad_pkg::DATA_W-1:0] TGT_RDATA_I,
	output logic [sad_pkg::TGT_N-1:0] TGT_SEL_O,
	output logic TGT_RD_O,
	output logic TGT_WR_O,
	output logic TGT_WORD_O,
	output logic [sad_pkg::ADDR_W-1:0] TGT_ADDR_O,
	output logic [sad_pkg::DATA_W-1:0] TGT_WDATA_O,
	// register sub-space selects
	output logic [3:0] CAN_MB_IDX_O,
	output logic CAN_REG_SEL_O,
	output logic GPIO_B_SEL_O,
	output logic GPIO_C_SEL_O,
	output logic [4:0] PERIPH_SUB_O
);
	// =====================================================================
	// decode of the incoming address
	logic [TGT_N-1:0] dec_sel;
	logic dec_reg;
	sad_wclass_t dec_wclass;
	logic [3:0] dec_mb;
	logic dec_can_reg;
	logic dec_gpb;
	logic dec_gpc;
	logic [4:0] dec_psub;

	sad_region_decode u_dec (
		.addr_i(BUS_ADDR_I),
		.tgt_sel_o(dec_sel),
		.reg_space_o(dec_reg),
		.wclass_o(dec_wclass),
		.can_mb_o(dec_mb),
		.can_reg_o(dec_can_reg),
		.gpb_o(dec_gpb),
		.gpc_o(dec_gpc),
		.psub_o(dec_psub)
	);

	function automatic logic [15:0] sel_data(input logic [TGT_N-1:0] sel,
		input logic [TGT_N-1:0][15:0] d);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < TGT_N; i++) begin
			if (sel[i]) begin
				r = r | d[i];
			end
		end
		return r;
	endfunction

	// =====================================================================
	// legality of the request
	sad_state_t state;
	sad_state_t next_state;
	wire req = BUS_RD_I | BUS_WR_I;
	wire take = (state == ST_IDLE) & req;
	wire mapped = |dec_sel;
	wire width_ok = (dec_wclass == W_ANY) ||
		(dec_wclass == W_BYTE && !BUS_WORD_I) ||
		(dec_wclass == W_WORD && BUS_WORD_I);
	wire align_ok = !dec_reg || !BUS_ADDR_I[0];
	wire legal = mapped & width_ok & align_ok;
	// byte access in register space drives only the low data lines
	wire byte_reg = dec_reg & ~BUS_WORD_I;
	wire [15:0] wdata_lane = byte_reg ? {8'h00, BUS_WDATA_I[7:0]} : BUS_WDATA_I;

	// =====================================================================
	// state machine: take, access, answer
	always_comb begin
		case (state)
			ST_IDLE: next_state = take ? ST_ACC : ST_IDLE;
			ST_ACC: next_state = ST_RESP;
			ST_RESP: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign BUS_BUSY_O = (state != ST_IDLE);
	assign BUS_READY_O = (state == ST_RESP);

	// =====================================================================
	// request capture; an illegal request never reaches a target
	logic req_ok;
	logic req_byte_reg;
	wire [TGT_N-1:0] next_sel = legal ? dec_sel : '0;

	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			TGT_SEL_O <= '0;
			TGT_RD_O <= 1'b0;
			TGT_WR_O <= 1'b0;
		end else if (take) begin
			TGT_SEL_O <= next_sel;
			TGT_RD_O <= BUS_RD_I & legal;
			TGT_WR_O <= BUS_WR_I & ~BUS_RD_I & legal;
		end else if (state == ST_ACC) begin
			TGT_SEL_O <= '0;
			TGT_RD_O <= 1'b0;
			TGT_WR_O <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			TGT_ADDR_O <= '0;
			TGT_WDATA_O <= '0;
			TGT_WORD_O <= 1'b0;
			req_ok <= 1'b0;
			req_byte_reg <= 1'b0;
		end else if (take) begin
			TGT_ADDR_O <= BUS_ADDR_I;
			TGT_WDATA_O <= wdata_lane;
			TGT_WORD_O <= BUS_WORD_I;
			req_ok <= legal;
			req_byte_reg <= byte_reg;
		end
	end

	// sub-space selects stand with the target select
	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			CAN_MB_IDX_O <= 4'h0;
			CAN_REG_SEL_O <= 1'b0;
			GPIO_B_SEL_O <= 1'b0;
			GPIO_C_SEL_O <= 1'b0;
			PERIPH_SUB_O <= 5'h00;
		end else if (take) begin
			CAN_MB_IDX_O <= legal ? dec_mb : 4'h0;
			CAN_REG_SEL_O <= legal & dec_can_reg;
			GPIO_B_SEL_O <= legal & dec_gpb;
			GPIO_C_SEL_O <= legal & dec_gpc;
			PERIPH_SUB_O <= legal ? dec_psub : 5'h00;
		end else if (state == ST_ACC) begin
			CAN_MB_IDX_O <= 4'h0;
			CAN_REG_SEL_O <= 1'b0;
			GPIO_B_SEL_O <= 1'b0;
			GPIO_C_SEL_O <= 1'b0;
			PERIPH_SUB_O <= 5'h00;
		end
	end

	// =====================================================================
	// read answer; reserved bits pass through unfiltered
	wire [15:0] raw_rdata = sel_data(TGT_SEL_O, TGT_RDATA_I);
	wire [15:0] next_rdata = !(req_ok & TGT_RD_O) ? RDATA_RST :
		(req_byte_reg ? {8'h00, raw_rdata[7:0]} : raw_rdata);

	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			BUS_RDATA_O <= RDATA_RST;
			BUS_ERR_O <= 1'b0;
		end else if (state == ST_ACC) begin
			BUS_RDATA_O <= next_rdata;
			BUS_ERR_O <= ~req_ok;
		end else if (state == ST_RESP) begin
			BUS_ERR_O <= 1'b0;
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_take_legal;
		take && legal;
	endsequence

	sequence s_answer;
		(state == ST_ACC) ##1 BUS_READY_O;
	endsequence

	sequence s_refused;
		TGT_SEL_O == '0 && !TGT_RD_O && !TGT_WR_O ##1 BUS_READY_O && BUS_ERR_O;
	endsequence

	a_flash_low: assert property (s_take_legal and sad_in(BUS_ADDR_I, PF_LO, PF_HI)
		|=> TGT_SEL_O[T_PFLASH] && $onehot(TGT_SEL_O))
		else $error("program flash not selected");

	a_sram_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, SR_LO, SR_HI)
		|=> TGT_SEL_O[T_SRAM] && $onehot(TGT_SEL_O))
		else $error("static ram not selected");

	a_brom_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, BR_LO, BR_HI)
		|=> TGT_SEL_O[T_BROM] && $onehot(TGT_SEL_O))
		else $error("boot rom not selected");

	a_dflash_sel: assert property (s_take_legal and BUS_ADDR_I == DH_HI
		|=> TGT_SEL_O[T_DFHI] ##1 TGT_SEL_O == '0)
		else $error("data flash select wrong");

	a_rsvd_none: assert property (take && sad_in(BUS_ADDR_I, DR_LO, DR_HI)
		|=> s_refused)
		else $error("reserved data flash range selected a target");

	a_can_mb_idx: assert property (s_take_legal and
		sad_in(BUS_ADDR_I, CAN_LO, CAN_MB_LAST)
		|=> TGT_SEL_O[T_CAN] && CAN_MB_IDX_O == TGT_ADDR_O[7:4])
		else $error("can buffer index wrong");

	a_can_reg_word: assert property (take && dec_can_reg && !BUS_WORD_I
		|=> TGT_SEL_O == '0 ##1 BUS_ERR_O && BUS_RDATA_O == RDATA_RST)
		else $error("byte access reached a can word register");

	a_biu_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, BIU_LO, BIU_HI)
		|=> TGT_SEL_O[T_BIU])
		else $error("bus interface unit not selected");

	a_port_byte: assert property (take && (dec_gpb || dec_gpc) && BUS_WORD_I
		|=> !GPIO_B_SEL_O && !GPIO_C_SEL_O && !TGT_WR_O)
		else $error("word access reached a port register");

	a_periph_sub: assert property (s_take_legal and BUS_ADDR_I == 17'h0fe00
		|=> TGT_SEL_O[T_PERI] && PERIPH_SUB_O == 5'h06)
		else $error("interrupt sub-range id wrong");

	a_upper_flash: assert property (take && BUS_ADDR_I[16]
		|=> TGT_SEL_O[T_PFLASH] == (TGT_ADDR_O >= PFU_LO))
		else $error("upper window decode wrong");

	a_odd_reg: assert property (take && dec_reg && BUS_ADDR_I[0]
		|=> TGT_SEL_O == '0 ##1 BUS_ERR_O)
		else $error("odd register address reached a target");

	a_byte_lane: assert property (BUS_READY_O && req_byte_reg
		|-> BUS_RDATA_O[15:8] == 8'h00)
		else $error("byte register read drove the high lines");

	a_unmap_zero: assert property (take && !mapped && BUS_RD_I
		|=> !TGT_RD_O ##1 BUS_READY_O && BUS_RDATA_O == RDATA_RST)
		else $error("unmapped read did not return zero");

	a_answer_time: assert property (take |=> s_answer ##1 !BUS_BUSY_O)
		else $error("answer not given two cycles after take");

	a_dflo_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, DL_LO, DL_HI)
		|=> TGT_SEL_O[T_DFLO] && $onehot(TGT_SEL_O))
		else $error("low endurance data flash not selected");

	a_can_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, CAN_LO, CAN_HI)
		|=> TGT_SEL_O[T_CAN] && $onehot(TGT_SEL_O))
		else $error("can space not selected");

	a_iox_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, IOX_LO, IOX_HI)
		|=> TGT_SEL_O[T_IOX] && $onehot(TGT_SEL_O))
		else $error("io expansion not selected");

	a_portb_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, GPB_LO, GPB_HI)
		|=> GPIO_B_SEL_O && !GPIO_C_SEL_O ##1 !GPIO_B_SEL_O)
		else $error("port b select wrong");

	a_portc_sel: assert property (s_take_legal and sad_in(BUS_ADDR_I, GPC_LO, GPC_HI)
		|=> GPIO_C_SEL_O && !GPIO_B_SEL_O ##1 !GPIO_C_SEL_O)
		else $error("port c select wrong");

	// gaps between the listed ranges must stay quiet
	a_gap_none: assert property (take && (
		(BUS_ADDR_I > SR_HI && BUS_ADDR_I < BR_LO) ||
		(BUS_ADDR_I > BR_HI && BUS_ADDR_I < DL_LO) ||
		(BUS_ADDR_I[16] && BUS_ADDR_I < PFU_LO)) |=> s_refused)
		else $error("unlisted address reached a target");

	a_bad_quiet: assert property (take && !legal
		|=> !CAN_REG_SEL_O && !GPIO_B_SEL_O && !GPIO_C_SEL_O &&
		CAN_MB_IDX_O == 4'h0 && PERIPH_SUB_O == 5'h00 && !TGT_RD_O && !TGT_WR_O)
		else $error("refused access drove a select or strobe");

	a_sel_onehot: assert property ($onehot0(TGT_SEL_O))
		else $error("more than one target selected");

	a_word_reg: assert property (take && dec_wclass == W_WORD && BUS_WORD_I
		&& !BUS_ADDR_I[0] |=> TGT_SEL_O[T_CAN] || TGT_SEL_O[T_BIU])
		else $error("word access to a word register refused");

	a_byte_reg: assert property (take && dec_wclass == W_BYTE && !BUS_WORD_I
		&& !BUS_ADDR_I[0] |=> TGT_SEL_O[T_IOX] || TGT_SEL_O[T_BIU])
		else $error("byte access to a byte register refused");

	a_wdata_lane: assert property (take && legal && byte_reg && BUS_WR_I && !BUS_RD_I
		|=> TGT_WR_O && TGT_WDATA_O == {8'h00, $past(BUS_WDATA_I[7:0])})
		else $error("byte register write carried high lines");

	a_rdata_pass: assert property (s_take_legal and BUS_RD_I && !dec_reg
		|=> ##1 BUS_RDATA_O == $past(raw_rdata))
		else $error("memory read data altered");

	a_rdata_hold: assert property (state != ST_ACC |=> $stable(BUS_RDATA_O))
		else $error("read data changed outside an answer");

	a_err_ready: assert property (BUS_ERR_O |-> BUS_READY_O)
		else $error("error flag outside the answer cycle");

	a_strobe_pulse: assert property (TGT_SEL_O != '0
		|=> TGT_SEL_O == '0 && !TGT_RD_O && !TGT_WR_O)
		else $error("target strobe stood longer than one cycle");

	a_periph_cmp: assert property (s_take_legal and BUS_ADDR_I == {1'b0, PSUB_CMP}
		|=> PERIPH_SUB_O == 5'(PSUB_N + 1))
		else $error("comparator sub-range id wrong");

	a_mb_last: assert property (s_take_legal and BUS_ADDR_I[16:4] == CAN_MB_LAST[16:4]
		|=> CAN_MB_IDX_O == 4'hf && TGT_SEL_O[T_CAN])
		else $error("last can buffer index wrong");

endmodule

// *** sad_decoder_bench.sv ***
/*
 * sad_decoder_bench: self-checking bench of the system address decoder.
 * Assumes the target model answers reads combinationally on select.
 */
`timescale 1ns/1ps
module sad_decoder_bench;
	import sad_pkg::*;

	typedef struct {
		logic [8:0] sel; logic rd; logic wr; logic [15:0] wd; logic [16:0] ad;
		logic [3:0] mb; logic cr; logic gb; logic gc; logic [4:0] ps;
		logic err; logic wz; logic [15:0] rdata;
	} sad_note_t;

	// =====================================================================
	// signals
	logic clk, rst, rd, wr, word, busy, ready, err, trd, twr, tword, creg, gpb, gpc;
	logic [16:0] addr, taddr, s_ad;
	logic [15:0] wdata, rdata_o, twdata, s_wd;
	logic [8:0] sel, s_sel;
	logic [8:0][15:0] trdata;
	logic [3:0] mb, s_mb;
	logic [4:0] psub, s_ps;
	logic s_rd, s_wr, s_cr, s_gb, s_gc, s_wz;
	int num_errors = 0;
	int cmp_count = 0;
	sad_note_t q[$];
	sad_note_t m;

	localparam logic [16:0] TBL [40] = '{
		17'h00000, 17'h0bfff, 17'h0c000, 17'h0cbff, 17'h0cc00, 17'h0dfff,
		17'h0e000, 17'h0e5ff, 17'h0e600, 17'h0e800, 17'h0efff, 17'h0f000, 17'h0f07f,
		17'h0f080, 17'h0f3ff, 17'h0f400, 17'h0f401, 17'h0f4f0, 17'h0f51e, 17'h0f520, 17'h0f7fe,
		17'h0f800, 17'h0f900, 17'h0f901, 17'h0f902, 17'h0f904, 17'h0fafe, 17'h0fb00, 17'h0fb16,
		17'h0fb20, 17'h0fc00, 17'h0fc40, 17'h0fe00, 17'h0ffc0, 17'h0ffe0, 17'h0fffe, 17'h10000,
		17'h1bfff, 17'h1c000, 17'h1ffff};

	sad_decoder u_sad_decoder (
		.MCLK_I(clk), .SYS_RST_I(rst), .BUS_ADDR_I(addr), .BUS_RD_I(rd), .BUS_WR_I(wr),
		.BUS_WORD_I(word), .BUS_WDATA_I(wdata), .BUS_BUSY_O(busy), .BUS_READY_O(ready),
		.BUS_ERR_O(err), .BUS_RDATA_O(rdata_o), .TGT_RDATA_I(trdata), .TGT_SEL_O(sel),
		.TGT_RD_O(trd), .TGT_WR_O(twr), .TGT_WORD_O(tword), .TGT_ADDR_O(taddr),
		.TGT_WDATA_O(twdata), .CAN_MB_IDX_O(mb), .CAN_REG_SEL_O(creg), .GPIO_B_SEL_O(gpb),
		.GPIO_C_SEL_O(gpc), .PERIPH_SUB_O(psub));

	sad_target_model u_sad_target_model (.clk_i(clk), .sel_i(sel), .addr_i(taddr),
		.rdata_o(trdata));

	// =====================================================================
	// expectations
	function automatic int exp_t(input logic [16:0] a, input logic sz);
		logic bsz;
		logic wsz;
		bsz = (a == BIU_CFG) || (a >= GPB_LO && a <= GPB_HI) || (a >= GPC_LO && a <= GPC_HI);
		wsz = (a >= CAN_LO && a <= CAN_REG_HI) || a == BIU_IOZ || a == BIU_SZ0;
		if (a >= PFU_LO) return T_PFLASH;
		if (a[16] || (a >= CAN_LO && a[0]) || (bsz && sz) || (wsz && !sz)) return -1;
		if (a <= PF_HI) return T_PFLASH;
		if (a <= SR_HI) return T_SRAM;
		if (a < BR_LO) return -1;
		if (a <= BR_HI) return T_BROM;
		if (a < DL_LO) return -1;
		if (a <= DL_HI) return T_DFLO;
		if (a <= DH_HI) return T_DFHI;
		if (a <= DR_HI) return -1;
		if (a <= CAN_HI) return T_CAN;
		if (a <= BIU_HI) return T_BIU;
		if (a <= IOX_HI) return T_IOX;
		return T_PERI;
	endfunction

	function automatic logic [4:0] exp_ps(input logic [15:0] a);
		exp_ps = 5'h00;
		for (int i = 0; i < PSUB_N; i++) begin
			if (a >= PSUB_LO[i] && a <= PSUB_HI[i]) exp_ps = 5'(i + 1);
		end
		if (a == PSUB_CMP || a == PSUB_CMP + 16'h0001) exp_ps = 5'h11;
	endfunction

	// =====================================================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// caller is idle on entry, so the request is taken at the next edge
	task automatic access(input logic [16:0] a, input logic r, input logic w, input logic sz,
		input logic [15:0] wd);
		sad_note_t n;
		int t;
		logic [15:0] d;
		logic regsp;
		t = exp_t(a, sz);
		regsp = (a >= CAN_LO) && !a[16];
		n = '{default: '0};
		n.err = (t < 0);
		if (t >= 0) begin
			n.sel[t] = 1'b1;
			n.rd = r;
			n.wr = !r;
			n.ad = a;
			n.wz = sz;
			n.wd = (regsp && !sz) ? {8'h00, wd[7:0]} : wd;
			n.mb = (a >= CAN_LO && a <= CAN_MB_LAST) ? a[7:4] : 4'h0;
			n.cr = (a >= CAN_REG_LO) && (a <= CAN_REG_HI);
			n.gb = (a >= GPB_LO) && (a <= GPB_HI);
			n.gc = (a >= GPC_LO) && (a <= GPC_HI);
			n.ps = (t == T_PERI) ? exp_ps(a[15:0]) : 5'h00;
			d = a[15:0] ^ (16'h1357 * 16'(t));
			if (r) n.rdata = (regsp && !sz) ? {8'h00, d[7:0]} : d;
		end
		q.push_back(n);
		addr = a;
		rd = r;
		wr = w;
		word = sz;
		wdata = wd;
		@(posedge clk);
		#1;
		rd = 1'b0;
		wr = 1'b0;
		for (int k = 0; k < 20 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		check("busy_end", busy, 1'b0);
	endtask

	// =====================================================================
	// monitor: snapshot the select cycle, compare at the answer
	always @(posedge clk) begin
		if (ready === 1'b1) begin
			if (q.size() == 0) begin
				check("note_queue", 1'b1, 1'b0);
			end else begin
				m = q.pop_front();
				check("sel", s_sel, m.sel);
				check("tgt_rd", s_rd, m.rd);
				check("tgt_wr", s_wr, m.wr);
				if (m.sel != 9'h000) check("tgt_addr", s_ad, m.ad);
				if (m.sel != 9'h000) check("tgt_word", s_wz, m.wz);
				if (m.wr) check("wdata", s_wd, m.wd);
				check("mbox", s_mb, m.mb);
				check("canreg", s_cr, m.cr);
				check("portb", s_gb, m.gb);
				check("portc", s_gc, m.gc);
				check("psub", s_ps, m.ps);
				check("err", err, m.err);
				check("rdata", rdata_o, m.rdata);
			end
		end else if (busy === 1'b1) begin
			s_sel = sel;
			s_rd = trd;
			s_wr = twr;
			s_ad = taddr;
			s_wz = tword;
			s_wd = twdata;
			s_mb = mb;
			s_cr = creg;
			s_gb = gpb;
			s_gc = gpc;
			s_ps = psub;
		end
	end

	// =====================================================================
	// clock, watchdog, tests
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#1000000;
		num_errors++;
		give_verdict();
	end

	initial begin
		logic [16:0] a;
		int v;
		rst = 1'b1;
		addr = '0;
		rd = 1'b0;
		wr = 1'b0;
		word = 1'b0;
		wdata = '0;
		void'($urandom(32'h1f480fea));
		repeat (10) @(posedge clk);
		#1;
		check("busy_rst", busy, 1'b0);
		check("sel_rst", sel, 9'h000);
		check("rdata_rst", rdata_o, 16'h0000);
		rst = 1'b0;
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			for (int sz = 0; sz < 2; sz++) begin
				access(TBL[i], 1'b1, 1'b0, 1'(sz), 16'hc3a5);
				access(TBL[i], 1'b0, 1'b1, 1'(sz), 16'hc3a5);
			end
		end
		$display("test map done");
		for (int i = 0; i < 300; i++) begin
			v = $urandom_range(1);
			a = v ? 17'h0f400 + 17'($urandom_range(3071)) : 17'($urandom);
			v = $urandom_range(2);
			access(a, v != 1, v != 0, 1'($urandom), 16'($urandom));
		end
		$display("test random done");
		// program flash and static RAM only, reserved high byte written as zero
		for (int i = 0; i < 60; i++) begin
			v = $urandom_range(1);
			a = 17'($urandom_range(SR_HI));
			access(a, v == 0, v == 1, 1'($urandom), {8'h00, 8'($urandom)});
		end
		$display("test listed done");
		check("note_left", q.size(), 0);
		give_verdict();
	end
endmodule

// *** sad_pkg.sv ***
/*
 * sad_pkg: shared constants, types and helpers of the system address decoder.
 * Assumes a 17-bit byte address from the processor and a 16-bit data bus.
 */
package sad_pkg;

	// =====================================================================
	// widths and target indices
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	localparam int TGT_N = 9;
	localparam int T_PFLASH = 0;
	localparam int T_SRAM = 1;
	localparam int T_BROM = 2;
	localparam int T_DFLO = 3;
	localparam int T_DFHI = 4;
	localparam int T_CAN = 5;
	localparam int T_BIU = 6;
	localparam int T_IOX = 7;
	localparam int T_PERI = 8;

	// =====================================================================
	// region bounds, inclusive
	localparam logic [16:0] PF_LO = 17'h00000;
	localparam logic [16:0] PF_HI = 17'h0bfff;
	localparam logic [16:0] SR_LO = 17'h0c000;
	localparam logic [16:0] SR_HI = 17'h0cbff;
	localparam logic [16:0] BR_LO = 17'h0e000;
	localparam logic [16:0] BR_HI = 17'h0e5ff;
	localparam logic [16:0] DL_LO = 17'h0e800;
	localparam logic [16:0] DL_HI = 17'h0efff;
	localparam logic [16:0] DH_LO = 17'h0f000;
	localparam logic [16:0] DH_HI = 17'h0f07f;
	localparam logic [16:0] DR_LO = 17'h0f080;
	localparam logic [16:0] DR_HI = 17'h0f3ff;
	localparam logic [16:0] CAN_LO = 17'h0f400;
	localparam logic [16:0] CAN_HI = 17'h0f7ff;
	localparam logic [16:0] BIU_LO = 17'h0f800;
	localparam logic [16:0] BIU_HI = 17'h0faff;
	localparam logic [16:0] IOX_LO = 17'h0fb00;
	localparam logic [16:0] IOX_HI = 17'h0fbff;
	localparam logic [16:0] PER_LO = 17'h0fc00;
	localparam logic [16:0] PER_HI = 17'h0ffff;
	localparam logic [16:0] PFU_LO = 17'h1c000;
	localparam logic [16:0] PFU_HI = 17'h1ffff;

	// =====================================================================
	// register sub-spaces
	localparam logic [16:0] CAN_MB_LAST = 17'h0f4ff;
	localparam int CAN_MB_LSB = 4;
	localparam logic [16:0] CAN_REG_LO = 17'h0f500;
	localparam logic [16:0] CAN_REG_HI = 17'h0f51f;
	localparam logic [16:0] BIU_CFG = 17'h0f900;
	localparam logic [16:0] BIU_IOZ = 17'h0f902;
	localparam logic [16:0] BIU_SZ0 = 17'h0f904;
	localparam logic [16:0] GPB_LO = 17'h0fb00;
	localparam logic [16:0] GPB_HI = 17'h0fb07;
	localparam logic [16:0] GPC_LO = 17'h0fb10;
	localparam logic [16:0] GPC_HI = 17'h0fb17;
	localparam logic [15:0] RDATA_RST = 16'h0000;

	// peripheral sub-ranges; id is index + 1, zero means none
	localparam int PSUB_N = 16;
	localparam logic [15:0] PSUB_LO [PSUB_N] = '{
		16'hfc40, 16'hfca0, 16'hfcc0, 16'hfce0, 16'hfd20, 16'hfe00,
		16'hfe40, 16'hfe60, 16'hfe80, 16'hfec0, 16'hfee0, 16'hff20,
		16'hff40, 16'hff60, 16'hff80, 16'hffc0};
	localparam logic [15:0] PSUB_HI [PSUB_N] = '{
		16'hfc8b, 16'hfca9, 16'hfcc9, 16'hfce9, 16'hfd29, 16'hfe1f,
		16'hfe4f, 16'hfe67, 16'hfe8f, 16'hfecb, 16'hfee9, 16'hff2b,
		16'hff51, 16'hff71, 16'hffa5, 16'hffd1};
	localparam logic [15:0] PSUB_CMP = 16'hffe0;

	// =====================================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ACC = 3'b010,
		ST_RESP = 3'b100
	} sad_state_t;

	typedef enum logic [1:0] {
		W_ANY = 2'h0,
		W_BYTE = 2'h1,
		W_WORD = 2'h2
	} sad_wclass_t;

	function automatic logic sad_in(input logic [16:0] a, input logic [16:0] lo,
		input logic [16:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

endpackage

// *** sad_region_decode.sv ***
/*
 * sad_region_decode: combinational map of a processor address onto targets
 * and register sub-spaces. Assumes a stable address from the caller.
 */
`timescale 1ns/1ps
module sad_region_decode
	import sad_pkg::*;
(
	// address
	input wire logic [sad_pkg::ADDR_W-1:0] addr_i,
	// decode results
	output logic [sad_pkg::TGT_N-1:0] tgt_sel_o,
	output logic reg_space_o,
	output sad_pkg::sad_wclass_t wclass_o,
	output logic [3:0] can_mb_o,
	output logic can_reg_o,
	output logic gpb_o,
	output logic gpc_o,
	output logic [4:0] psub_o
);
	wire low64 = ~addr_i[16];
	wire [16:0] a = addr_i;

	// upper window shares the program flash target
	assign tgt_sel_o[T_PFLASH] = sad_in(a, PF_LO, PF_HI) | sad_in(a, PFU_LO, PFU_HI);
	assign tgt_sel_o[T_SRAM] = sad_in(a, SR_LO, SR_HI);
	assign tgt_sel_o[T_BROM] = sad_in(a, BR_LO, BR_HI);
	assign tgt_sel_o[T_DFLO] = sad_in(a, DL_LO, DL_HI);
	assign tgt_sel_o[T_DFHI] = sad_in(a, DH_LO, DH_HI);
	assign tgt_sel_o[T_CAN] = sad_in(a, CAN_LO, CAN_HI);
	assign tgt_sel_o[T_BIU] = sad_in(a, BIU_LO, BIU_HI);
	assign tgt_sel_o[T_IOX] = sad_in(a, IOX_LO, IOX_HI);
	assign tgt_sel_o[T_PERI] = sad_in(a, PER_LO, PER_HI);

	assign reg_space_o = low64 & (a >= CAN_LO);
	assign can_reg_o = sad_in(a, CAN_REG_LO, CAN_REG_HI);
	wire can_mb = sad_in(a, CAN_LO, CAN_MB_LAST);
	assign can_mb_o = can_mb ? a[CAN_MB_LSB +: 4] : 4'h0;
	assign gpb_o = sad_in(a, GPB_LO, GPB_HI);
	assign gpc_o = sad_in(a, GPC_LO, GPC_HI);

	// width class of the register at this address, where it is known
	wire w_word = can_mb | can_reg_o | (a == BIU_IOZ) | (a == BIU_SZ0);
	wire w_byte = gpb_o | gpc_o | (a == BIU_CFG);
	assign wclass_o = w_word ? W_WORD : (w_byte ? W_BYTE : W_ANY);

	always_comb begin
		psub_o = 5'h00;
		if (tgt_sel_o[T_PERI]) begin
			for (int i = 0; i < PSUB_N; i++) begin
				if (a[15:0] >= PSUB_LO[i] && a[15:0] <= PSUB_HI[i]) begin
					psub_o = 5'(i + 1);
				end
			end
			if (a[15:0] == PSUB_CMP || a[15:0] == PSUB_CMP + 16'h0001) begin
				psub_o = 5'(PSUB_N + 1);
			end
		end
	end

endmodule

// *** sad_target_model.sv ***
/*
 * sad_target_model: behavioural stand-in for the memories and register files
 * behind the decoder. Assumes the decoder's select and address are registered.
 */
`timescale 1ns/1ps
module sad_target_model
	import sad_pkg::*;
(
	// clock
	input wire logic clk_i,
	// decoder side
	input wire logic [sad_pkg::TGT_N-1:0] sel_i,
	input wire logic [sad_pkg::ADDR_W-1:0] addr_i,
	output logic [sad_pkg::TGT_N-1:0][sad_pkg::DATA_W-1:0] rdata_o
);
	// =====================================================================
	// read data
	// unselected targets churn so a stale value never looks valid
	logic [15:0] noise;

	initial noise = 16'h5a3c;

	always @(posedge clk_i) begin
		noise <= {noise[14:0], noise[15] ^ noise[13]};
	end

	always_comb begin
		for (int t = 0; t < TGT_N; t++) begin
			rdata_o[t] = sel_i[t] ? (addr_i[15:0] ^ (16'h1357 * 16'(t))) : (noise ^ 16'(t));
		end
	end
endmodule
